/* bench/hlpc_cfg_source.sv */
// Purpose: far-side model: eeprom loader and smbus host writing the config byte
// Assumes: one request pulse gives one write strobe, one cycle later
// Notes:   idle address and data lines show the inverse of their last value
`timescale 1ns/1ps
module hlpc_cfg_source (
    input wire logic clk_i,
    input wire logic req_i,
    input wire logic use_smbus_i,
    input wire logic [7:0] addr_i,
    input wire logic [7:0] data_i,
    output logic ee_wr_o,
    output logic sm_wr_o,
    output logic [7:0] addr_o,
    output logic [7:0] data_o
);
    ////////////////////////////////////////////////////////
    // known idle state at time zero
    initial begin
        ee_wr_o = 1'h0;
        sm_wr_o = 1'h0;
        addr_o = 8'h00;
        data_o = 8'h00;
    end
    // one-cycle strobe on the chosen bus; released lines never hold a stale value
    always @(posedge clk_i) begin
        ee_wr_o <= req_i && !use_smbus_i;
        sm_wr_o <= req_i && use_smbus_i;
        addr_o <= req_i ? addr_i : ~addr_o;
        data_o <= req_i ? data_i : ~data_o;
    end
endmodule : hlpc_cfg_source

/* bench/hlpc_config_bits_test.sv */
// Purpose: self-checking bench for the hub link power configuration bits
// Assumes: writes reach the design through the far-side model
// Notes:   reset read first, then table rows, then link power and reset cases by hand
`timescale 1ns/1ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin bad_count++; \
    $display("CHECK FAILED t=%0t got=%h exp=%h", $time, a, e); end end
module hlpc_config_bits_test;
    import hlpc_pkg::*;
    typedef struct packed {
        logic mode; logic smb; logic [7:0] wd; logic [3:0] req;
        logic [7:0] rd; logic blk; logic rpt; logic [3:0] pins;
    } hlpc_row_t;
    logic core_clk_i = 1'h0, rst_b_i = 1'h0, smbus_mode_i = 1'h0, req = 1'h0, use_smb = 1'h0;
    logic cfg_rd_i = 1'h0, flpma_event_i = 1'h0, upstream_disconnect_i = 1'h0;
    logic [7:0] addr = 8'h00, data = 8'h00, cfg_rd_addr_i = 8'h00, a_w, d_w, cfg_rdata_o;
    logic [3:0] port_on_req_i = 4'h0, port_power_enable_pins_o;
    logic ee_wr, sm_wr, cfg_rvalid_o, link_low_power_block_o, power_report_en_o;
    int bad_count = 0, n_tests = 0;
    hlpc_row_t rows [6] = '{
        {1'h0, 1'h0, 8'hff, 4'h4, 8'h3c, 1'h1, 1'h0, 4'h1},
        {1'h0, 1'h0, 8'h00, 4'ha, 8'h10, 1'h0, 1'h1, 4'ha},
        {1'h1, 1'h1, 8'h28, 4'h0, 8'h38, 1'h1, 1'h1, 4'h0},
        {1'h1, 1'h0, 8'hff, 4'h8, 8'h38, 1'h1, 1'h1, 4'h1},
        {1'h0, 1'h1, 8'h04, 4'h2, 8'h38, 1'h1, 1'h1, 4'h1},
        {1'h0, 1'h0, 8'h04, 4'h6, 8'h14, 1'h0, 1'h0, 4'h6}};
    ////////////////////////////////////////////////////////
    always #2 core_clk_i = ~core_clk_i;
    hlpc_cfg_source hlpc_cfg_source_inst (.clk_i(core_clk_i), .req_i(req),
        .use_smbus_i(use_smb), .addr_i(addr), .data_i(data), .ee_wr_o(ee_wr),
        .sm_wr_o(sm_wr), .addr_o(a_w), .data_o(d_w));
    hlpc_config_bits hlpc_config_bits_inst (.core_clk_i(core_clk_i), .rst_b_i(rst_b_i),
        .smbus_mode_i(smbus_mode_i), .eeprom_wr_i(ee_wr), .eeprom_addr_i(a_w),
        .eeprom_wdata_i(d_w), .smbus_wr_i(sm_wr), .smbus_addr_i(a_w), .smbus_wdata_i(d_w),
        .cfg_rd_i(cfg_rd_i), .cfg_rd_addr_i(cfg_rd_addr_i), .flpma_event_i(flpma_event_i),
        .upstream_disconnect_i(upstream_disconnect_i), .port_on_req_i(port_on_req_i),
        .cfg_rdata_o(cfg_rdata_o), .cfg_rvalid_o(cfg_rvalid_o),
        .link_low_power_block_o(link_low_power_block_o),
        .power_report_en_o(power_report_en_o),
        .port_power_enable_pins_o(port_power_enable_pins_o));
    ////////////////////////////////////////////////////////
    // write through the model, then let block and pins settle
    task automatic wr(input logic smb, input logic [7:0] a, input logic [7:0] d);
        @(posedge core_clk_i) begin req <= 1'h1; use_smb <= smb; addr <= a; data <= d; end
        @(posedge core_clk_i) req <= 1'h0;
        repeat (3) @(posedge core_clk_i);
        #1;
    endtask : wr
    // read strobe, data with valid one cycle later, valid gone the next
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge core_clk_i) begin cfg_rd_i <= 1'h1; cfg_rd_addr_i <= a; end
        @(posedge core_clk_i) cfg_rd_i <= 1'h0;
        #1;
        `CHK(cfg_rvalid_o, 1'h1)
        `CHK(cfg_rdata_o, e)
        @(posedge core_clk_i) #1;
        `CHK(cfg_rvalid_o, 1'h0)
    endtask : rd
    // one pulse on either or both link event inputs, checked two edges later
    task automatic pulse(input logic dis, input logic fl, input logic e);
        @(posedge core_clk_i) begin upstream_disconnect_i <= dis; flpma_event_i <= fl; end
        @(posedge core_clk_i) begin upstream_disconnect_i <= 1'h0; flpma_event_i <= 1'h0; end
        @(posedge core_clk_i) #1;
        `CHK(link_low_power_block_o, e)
    endtask : pulse
    task automatic final_report();
        $display("compares %0d mismatches %0d", n_tests, bad_count);
        if (bad_count == 0 && n_tests > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask : final_report
    ////////////////////////////////////////////////////////
    initial begin
        repeat (12) @(posedge core_clk_i);
        rst_b_i <= 1'h1;
        rd(8'h05, 8'h10);
        foreach (rows[i]) begin
            @(posedge core_clk_i) begin
                smbus_mode_i <= rows[i].mode;
                port_on_req_i <= rows[i].req;
            end
            wr(rows[i].smb, 8'h05, rows[i].wd);
            `CHK(link_low_power_block_o, rows[i].blk)
            `CHK(power_report_en_o, rows[i].rpt)
            `CHK(port_power_enable_pins_o, rows[i].pins)
            rd(8'h05, rows[i].rd);
        end
        rd(8'h06, 8'h00);
        @(posedge core_clk_i) smbus_mode_i <= 1'h1;
        wr(1'h1, 8'h07, 8'hff);
        rd(8'h05, 8'h14);
        wr(1'h1, 8'h05, 8'h20);
        `CHK(link_low_power_block_o, 1'h1)
        pulse(1'h0, 1'h1, 1'h0);
        wr(1'h1, 8'h05, 8'h20);
        `CHK(link_low_power_block_o, 1'h0)
        pulse(1'h1, 1'h0, 1'h1);
        // force-accept and disconnect in one cycle: the force-accept wins
        pulse(1'h1, 1'h1, 1'h0);
        @(posedge core_clk_i) rst_b_i <= 1'h0;
        @(posedge core_clk_i) #1;
        `CHK(port_power_enable_pins_o, 4'h0)
        `CHK(link_low_power_block_o, 1'h0)
        `CHK(power_report_en_o, 1'h0)
        @(posedge core_clk_i) rst_b_i <= 1'h1;
        rd(8'h05, 8'h10);
        // reset must have dropped the force-accept latch
        wr(1'h1, 8'h05, 8'h20);
        `CHK(link_low_power_block_o, 1'h1)
        final_report();
    end
    // watchdog well past the roughly 110 cycles the tests need
    initial begin
        #20000;
        bad_count++;
        final_report();
    end
endmodule : hlpc_config_bits_test

/* rtl/hlpc_config_bits.sv */
//////////////////////////////////////////////////////////////////////////////////////////////////
// Purpose: device configuration bits 5:2 of the hub: link low-power block, ganged power,
//          power switching status reporting, and the power enable pins they steer
// Assumes: loader, smbus slave and link logic all run on core_clk_i
// Notes:   read data comes back one cycle after the read strobe
//////////////////////////////////////////////////////////////////////////////////////////////////
`timescale 1ns/1ps

// Notes on behaviour
// - bit 5 at one blocks all U1/U2 initiation and acceptance on every port
// - a sent or received force-accept LMP lifts the U1/U2 block
// - once lifted, the block stays lifted until power-on reset or upstream disconnect
// - in i2c mode the fields are loaded from eeprom contents
// - in smbus mode an smbus host may overwrite the fields; hub accepts
// - bit 4 is read-only and always reads one
// - reporting on and bit 3 zero: each port power pin driven on its own
// - reporting on and bit 3 one: all ports ganged on the first port pin
// - bit 2 zero enables power switching status reporting, one disables it
// - after reset the byte reads 00010000
module hlpc_config_bits
    import hlpc_pkg::*;
(
    input wire logic core_clk_i,
    input wire logic rst_b_i,
    input wire logic smbus_mode_i,
    input wire logic eeprom_wr_i,
    input wire logic [7:0] eeprom_addr_i,
    input wire logic [7:0] eeprom_wdata_i,
    input wire logic smbus_wr_i,
    input wire logic [7:0] smbus_addr_i,
    input wire logic [7:0] smbus_wdata_i,
    input wire logic cfg_rd_i,
    input wire logic [7:0] cfg_rd_addr_i,
    input wire logic flpma_event_i,
    input wire logic upstream_disconnect_i,
    input wire logic [HLPC_NUM_PORTS-1:0] port_on_req_i,
    output logic [7:0] cfg_rdata_o,
    output logic cfg_rvalid_o,
    output logic link_low_power_block_o,
    output logic power_report_en_o,
    output logic [HLPC_NUM_PORTS-1:0] port_power_enable_pins_o
);

    //////////////////////////////////////////////////////////////////////////////////////////////
    // stored fields and state
    logic cfg_lp_block;
    logic cfg_ganged;
    logic cfg_rpt_off;
    logic lp_reenabled;

    //////////////////////////////////////////////////////////////////////////////////////////////
    // write decode: the loader owns the byte in i2c mode, the smbus host in smbus mode
    wire eeprom_hit = eeprom_wr_i && !smbus_mode_i && (eeprom_addr_i == HLPC_CFG_OFFSET);
    wire smbus_hit = smbus_wr_i && smbus_mode_i && (smbus_addr_i == HLPC_CFG_OFFSET);
    wire [7:0] wr_data = smbus_hit ? smbus_wdata_i : eeprom_wdata_i;
    wire wr_hit = eeprom_hit || smbus_hit;
    wire [2:0] eeprom_bits = {eeprom_wdata_i[HLPC_LP_BLOCK_BIT],
        eeprom_wdata_i[HLPC_GANGED_BIT], eeprom_wdata_i[HLPC_RPT_OFF_BIT]};
    wire [2:0] smbus_bits = {smbus_wdata_i[HLPC_LP_BLOCK_BIT],
        smbus_wdata_i[HLPC_GANGED_BIT], smbus_wdata_i[HLPC_RPT_OFF_BIT]};
    wire [2:0] cfg_bits = {cfg_lp_block, cfg_ganged, cfg_rpt_off};

    // field update on an accepted write
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_lp_block <= HLPC_LP_BLOCK_RESET;
            cfg_ganged <= HLPC_GANGED_RESET;
            cfg_rpt_off <= HLPC_RPT_OFF_RESET;
        end else if (wr_hit) begin
            cfg_lp_block <= wr_data[HLPC_LP_BLOCK_BIT];
            cfg_ganged <= wr_data[HLPC_GANGED_BIT];
            cfg_rpt_off <= wr_data[HLPC_RPT_OFF_BIT];
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // read path: bit 4 is a constant one, foreign bits read zero
    wire rd_hit = cfg_rd_addr_i == HLPC_CFG_OFFSET;
    wire [7:0] cfg_view = {2'h0, cfg_lp_block, HLPC_RSVD_ONE_VALUE, cfg_ganged, cfg_rpt_off,
        2'h0};
    wire [7:0] next_rdata = rd_hit ? cfg_view : HLPC_UNMAPPED_DATA;

    // registered read answer
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_rdata_o <= 8'h00;
            cfg_rvalid_o <= 1'h0;
        end else begin
            cfg_rvalid_o <= cfg_rd_i;
            if (cfg_rd_i) begin
                cfg_rdata_o <= next_rdata;
            end
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // force-accept latch: set wins over a disconnect in the same cycle
    wire next_reenabled = flpma_event_i ? 1'h1 : (upstream_disconnect_i ? 1'h0 : lp_reenabled);
    wire next_lp_block = cfg_lp_block && !lp_reenabled;

    // the latch only clears on power-on reset or upstream disconnect
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            lp_reenabled <= 1'h0;
            link_low_power_block_o <= 1'h0;
        end else begin
            lp_reenabled <= next_reenabled;
            link_low_power_block_o <= next_lp_block;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // port power pins: per port, or all ports on the first pin when ganged
    wire any_port_req = |port_on_req_i;
    wire [HLPC_NUM_PORTS-1:0] ganged_pins;
    wire [HLPC_NUM_PORTS-1:0] next_pins;
    genvar gi;
    generate
        for (gi = 0; gi < HLPC_NUM_PORTS; gi = gi + 1) begin : g_port
            if (gi == 0) begin : g_first
                assign ganged_pins[gi] = any_port_req;
            end else begin : g_rest
                assign ganged_pins[gi] = 1'h0;
            end
            assign next_pins[gi] = cfg_ganged ? ganged_pins[gi]
                : port_on_req_i[gi];
        end
    endgenerate
    wire next_report_en = !cfg_rpt_off;

    // registered pin and report outputs
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            port_power_enable_pins_o <= '0;
            power_report_en_o <= 1'h0;
        end else begin
            port_power_enable_pins_o <= next_pins;
            power_report_en_o <= next_report_en;
        end
    end

    //////////////////////////////////////////////////////////////////////////////////////////////
    // checks
    logic first_cycle;
    always_ff @(posedge core_clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            first_cycle <= 1'h1;
        end else begin
            first_cycle <= 1'h0;
        end
    end

    default clocking cb @(posedge core_clk_i);
    endclocking
    default disable iff (!rst_b_i);

    property p_lp_block;
        1'b1 |=> link_low_power_block_o == ($past(cfg_lp_block) && !$past(lp_reenabled));
    endproperty
    a_lp_block: assert property (p_lp_block) else $error("link block mismatch");

    property p_flpma_lifts;
        flpma_event_i |=> ##1 !link_low_power_block_o;
    endproperty
    a_flpma_lifts: assert property (p_flpma_lifts) else $error("not lifted");

    property p_reen_holds;
        lp_reenabled && !upstream_disconnect_i |=> lp_reenabled;
    endproperty
    a_reen_holds: assert property (p_reen_holds) else $error("reenable lost");

    property p_disc_clears;
        upstream_disconnect_i && !flpma_event_i |=> !lp_reenabled ##1
            (link_low_power_block_o == $past(cfg_lp_block));
    endproperty
    a_disc_clears: assert property (p_disc_clears) else $error("not cleared");

    property p_eeprom_load;
        eeprom_hit |=> cfg_bits == $past(eeprom_bits);
    endproperty
    a_eeprom_load: assert property (p_eeprom_load) else $error("load lost");

    property p_smbus_write;
        smbus_hit |=> cfg_bits == $past(smbus_bits);
    endproperty
    a_smbus_write: assert property (p_smbus_write) else $error("write lost");

    property p_rsvd_one;
        cfg_rd_i && rd_hit |=> cfg_rvalid_o && cfg_rdata_o[HLPC_RSVD_ONE_BIT];
    endproperty
    a_rsvd_one: assert property (p_rsvd_one) else $error("reserved bit not one");

    property p_per_port;
        !cfg_ganged |=> port_power_enable_pins_o == $past(port_on_req_i);
    endproperty
    a_per_port: assert property (p_per_port) else $error("per-port pins wrong");

    property p_ganged;
        cfg_ganged |=> port_power_enable_pins_o == {3'h0, $past(any_port_req)};
    endproperty
    a_ganged: assert property (p_ganged) else $error("ganged pins wrong");

    property p_report;
        1'b1 |=> power_report_en_o == !$past(cfg_rpt_off);
    endproperty
    a_report: assert property (p_report) else $error("report enable wrong");

    property p_reset_value;
        first_cycle |-> cfg_view == HLPC_CFG_RESET;
    endproperty
    a_reset_value: assert property (p_reset_value) else $error("bad reset");

    property p_unreported;
        cfg_rpt_off ##1 cfg_rpt_off |-> !power_report_en_o;
    endproperty
    a_unreported: assert property (p_unreported) else $error("reporting not off");

    property p_cov_reenable;
        cfg_lp_block && flpma_event_i ##2 !link_low_power_block_o;
    endproperty
    c_cov_reenable: cover property (p_cov_reenable);

    property p_cov_ganged_on;
        cfg_ganged && any_port_req ##1 port_power_enable_pins_o[0];
    endproperty
    c_cov_ganged_on: cover property (p_cov_ganged_on);

    property p_cov_smbus;
        smbus_hit ##1 cfg_rd_i && rd_hit ##1 cfg_rvalid_o;
    endproperty
    c_cov_smbus: cover property (p_cov_smbus);

    property p_cov_eeprom;
        eeprom_hit ##1 cfg_lp_block;
    endproperty
    c_cov_eeprom: cover property (p_cov_eeprom);

endmodule : hlpc_config_bits

/* rtl/hlpc_pkg.sv */
//////////////////////////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the hub link power configuration bits
// Assumes: one 8-bit configuration byte, bits 5:2 handled here
// Notes:   bits 7:6 and 1:0 belong to other logic and read as zero here
//////////////////////////////////////////////////////////////////////////////////////////////////
package hlpc_pkg;
    // register placement and width
    localparam logic [7:0] HLPC_CFG_OFFSET = 8'h05;
    localparam int HLPC_DATA_W = 8;
    localparam int HLPC_NUM_PORTS = 4;
    // field positions
    localparam int HLPC_LP_BLOCK_BIT = 5;
    localparam int HLPC_RSVD_ONE_BIT = 4;
    localparam int HLPC_GANGED_BIT = 3;
    localparam int HLPC_RPT_OFF_BIT = 2;
    // value after reset of the whole byte and of the writable fields
    localparam logic [7:0] HLPC_CFG_RESET = 8'h10;
    localparam logic HLPC_LP_BLOCK_RESET = 1'h0;
    localparam logic HLPC_GANGED_RESET = 1'h0;
    localparam logic HLPC_RPT_OFF_RESET = 1'h0;
    localparam logic HLPC_RSVD_ONE_VALUE = 1'h1;
    // read data of an unmapped offset
    localparam logic [7:0] HLPC_UNMAPPED_DATA = 8'h00;
endpackage : hlpc_pkg
